/* File: uctl_pkg.sv */
// package: register map, field layouts and constants of the serial port
package uctl_pkg;

   // =====================================================================
   // register map (index; byte address is four times the index)
   localparam int ADDR_W = 10;
   localparam logic [7:0] IDX_CTRL   = 8'h98;
   localparam logic [7:0] IDX_DATA   = 8'h99;
   localparam logic [7:0] IDX_CLKSEL = 8'h9A;
   localparam logic [7:0] IDX_MASK   = 8'h9B;
   localparam logic [7:0] IDX_STAT   = 8'h9C;

   // =====================================================================
   // reset values
   localparam logic [7:0] CTRL_RST   = 8'h40;
   localparam logic [7:0] DATA_RST   = 8'h00;
   localparam logic [7:0] CLKSEL_RST = 8'h00;
   localparam logic [7:0] MASK_RST   = 8'h00;

   // =====================================================================
   // status and mask bit positions
   localparam int STAT_TX  = 0;
   localparam int STAT_RX  = 1;
   localparam int STAT_OVR = 2;

   // =====================================================================
   // timing
   localparam int OVS_DEF = 16;
   localparam int DIV_P01 = 4;
   localparam int DIV_P00 = 12;
   localparam int DIV_P10 = 48;
   localparam logic [1:0] PS_DIV12 = 2'h0;
   localparam logic [1:0] PS_DIV4  = 2'h1;
   localparam logic [1:0] PS_DIV48 = 2'h2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // =====================================================================
   // types
   typedef struct packed {
      logic frame_mode_select;
      logic unused_one;
      logic multiproc_enable;
      logic receive_enable_bit;
      logic tx_ninth_bit;
      logic rx_ninth_bit;
      logic tx_done_flag;
      logic rx_done_flag;
   } uctl_ctrl_s;

   typedef struct packed {
      logic [4:0] rsvd;
      logic       timer_clock_bypass;
      logic [1:0] timer_prescale_select;
   } uctl_clksel_s;

   typedef enum logic [2:0] {
      S_IDLE  = 3'h0,
      S_START = 3'h1,
      S_DATA  = 3'h2,
      S_NINTH = 3'h3,
      S_STOP  = 3'h4
   } uctl_bit_e;

   typedef enum logic [2:0] {
      SEL_NONE   = 3'h0,
      SEL_CTRL   = 3'h1,
      SEL_DATA   = 3'h2,
      SEL_CLKSEL = 3'h3,
      SEL_MASK   = 3'h4,
      SEL_STAT   = 3'h5
   } uctl_sel_e;

endpackage

/* File: uctl_prescale.sv */
// bit-rate timer clock enable: bypass or fixed prescale of the system clock
`timescale 1ns/1ps
module uctl_prescale (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire uctl_pkg::uctl_clksel_s clksel,
   output logic                       timer_clk_en
);
   import uctl_pkg::*;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   logic [5:0] cnt_q;
   logic [5:0] last;

   always_comb begin
      case (clksel.timer_prescale_select)
         PS_DIV4:  last = 6'(DIV_P01 - 1);
         PS_DIV48: last = 6'(DIV_P10 - 1);
         default:  last = 6'(DIV_P00 - 1);
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q        <= 6'h00;
         timer_clk_en <= 1'b0;
      end else if (clksel.timer_clock_bypass) begin
         cnt_q        <= 6'h00;
         timer_clk_en <= 1'b1;
      end else if (cnt_q >= last) begin
         cnt_q        <= 6'h00;
         timer_clk_en <= 1'b1;
      end else begin
         cnt_q        <= cnt_q + 6'h01;
         timer_clk_en <= 1'b0;
      end
   end

   sequence s_div4_gap;
      !timer_clk_en [*3] ##1 timer_clk_en;
   endsequence

   a_bypass_full_rate: assert property (
      clksel.timer_clock_bypass |=> timer_clk_en)
      else $error("bypass did not give a full-rate enable");

   a_div4_spacing: assert property (
      (timer_clk_en && $stable(clksel) && !clksel.timer_clock_bypass
       && clksel.timer_prescale_select == PS_DIV4 && cnt_q == 6'h00
       && $past(cnt_q) == 6'(DIV_P01 - 1))
      // a prescale rewrite inside the gap excuses it
      |-> (##1 s_div4_gap) or (##[1:4] $changed(clksel)))
      else $error("divide by four spacing wrong");

endmodule

/* File: uctl_top.sv */
// serial port 0: control, status, data buffer, frame engine, AXI4-Lite
// How it works
// - frames starting while receive enable is 0 are ignored.
// - nine-bit mode sends tx ninth bit; eight-bit mode ignores it.
// - accepted frame puts stop bit or ninth bit into rx ninth bit.
// - tx done sets at stop-bit start in both modes.
// - tx done flag raises interrupt when its mask bit is set.
// - hardware never clears done flags; software clears them.
// - rx done sets when the stop bit is sampled.
// - rx done flag raises interrupt when its mask bit is set.
// - data buffer write loads the transmit shifter, not the rx latch.
// - every data buffer write starts a new frame.
// - data buffer read returns the receive latch.
// - bypass gives system clock; else prescale 01/00/10 is /4/12/48.
// - mode bit 0 is eight-bit frames, 1 is nine-bit frames.
// - multiproc enable accepts a frame only if its ninth bit is 1.
// - latch and ninth bit load only while rx done is 0.
// - frame is start, eight data bits lsb first, optional ninth, stop.
`timescale 1ns/1ps
module uctl_top #(
   parameter int OVS = uctl_pkg::OVS_DEF
) (
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   input  wire logic [uctl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [uctl_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   input  wire logic                        baud_tick,
   input  wire logic                        rxd,
   output logic                             txd,
   output logic                             timer_clk_en,
   output logic                             irq
);
   import uctl_pkg::*;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   localparam int CW = $clog2(OVS);
   localparam logic [CW-1:0] CNT_LAST = CW'(OVS - 1);
   localparam logic [CW-1:0] CNT_HALF = CW'(OVS / 2 - 1);

   function automatic uctl_sel_e reg_sel(input logic [ADDR_W-1:0] a);
      case (a)
         {IDX_CTRL, 2'h0}:   reg_sel = SEL_CTRL;
         {IDX_DATA, 2'h0}:   reg_sel = SEL_DATA;
         {IDX_CLKSEL, 2'h0}: reg_sel = SEL_CLKSEL;
         {IDX_MASK, 2'h0}:   reg_sel = SEL_MASK;
         {IDX_STAT, 2'h0}:   reg_sel = SEL_STAT;
         default:            reg_sel = SEL_NONE;
      endcase
   endfunction

   uctl_ctrl_s        ctrl_q;
   uctl_clksel_s      clksel_q;
   logic [7:0]        mask_q;
   logic [7:0]        rx_latch_q;
   logic              ovr_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [7:0]        w_data_q;
   logic              w_lane0_q;
   logic              aw_got_q;
   logic              w_got_q;
   uctl_bit_e         tx_st_q;
   uctl_bit_e         rx_st_q;
   logic [CW-1:0]     tx_cnt_q;
   logic [CW-1:0]     rx_cnt_q;
   logic [2:0]        tx_bit_q;
   logic [2:0]        rx_bit_q;
   logic [7:0]        tx_sh_q;
   logic [7:0]        rx_sh_q;
   logic              rx_ninth_q;
   logic              rxd_prev_q;

   // =====================================================================
   // AXI4-Lite write channel
   logic      wr_go;
   uctl_sel_e wr_sel;
   logic      wr_ctrl;
   logic      wr_data;
   logic      wr_clksel;
   logic      wr_mask;
   logic      wr_stat;
   uctl_ctrl_s w_ctrl;

   assign wr_go     = aw_got_q && w_got_q && !s_axi_bvalid;
   assign wr_sel    = reg_sel(aw_addr_q);
   assign wr_ctrl   = wr_go && w_lane0_q && wr_sel == SEL_CTRL;
   assign wr_data   = wr_go && w_lane0_q && wr_sel == SEL_DATA;
   assign wr_clksel = wr_go && w_lane0_q && wr_sel == SEL_CLKSEL;
   assign wr_mask   = wr_go && w_lane0_q && wr_sel == SEL_MASK;
   assign wr_stat   = wr_go && w_lane0_q && wr_sel == SEL_STAT;
   assign w_ctrl    = w_data_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         aw_got_q      <= 1'b0;
         aw_addr_q     <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_got_q      <= 1'b1;
         aw_addr_q     <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_got_q      <= 1'b0;
      end else if (!aw_got_q && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_wready <= 1'b0;
         w_got_q      <= 1'b0;
         w_data_q     <= 8'h00;
         w_lane0_q    <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_got_q      <= 1'b1;
         w_data_q     <= s_axi_wdata[7:0];
         w_lane0_q    <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_got_q      <= 1'b0;
      end else if (!w_got_q && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // =====================================================================
   // AXI4-Lite read channel
   logic [7:0] rd_byte;
   uctl_sel_e  rd_sel;

   assign rd_sel = reg_sel(s_axi_araddr);

   always_comb begin
      case (rd_sel)
         SEL_CTRL:   rd_byte = ctrl_q | CTRL_RST;
         SEL_DATA:   rd_byte = rx_latch_q;
         SEL_CLKSEL: rd_byte = clksel_q;
         SEL_MASK:   rd_byte = mask_q;
         SEL_STAT:   rd_byte = {5'h00, ovr_q, ctrl_q.rx_done_flag,
                                ctrl_q.tx_done_flag};
         default:    rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, rd_byte};
         s_axi_rresp   <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid) begin
         s_axi_rvalid  <= !s_axi_rready;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // =====================================================================
   // transmitter
   logic tx_bit_end;
   logic tx_ti_set;

   assign tx_bit_end = baud_tick && tx_cnt_q == CNT_LAST;
   assign tx_ti_set  = tx_bit_end && ((tx_st_q == S_DATA && tx_bit_q == 3'h7
                       && !ctrl_q.frame_mode_select)
                       || tx_st_q == S_NINTH);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_st_q  <= S_IDLE;
         tx_cnt_q <= '0;
         tx_bit_q <= 3'h0;
         tx_sh_q  <= DATA_RST;
         txd      <= 1'b1;
      end else if (wr_data) begin
         tx_st_q  <= S_START;
         tx_cnt_q <= '0;
         tx_bit_q <= 3'h0;
         tx_sh_q  <= w_data_q;
         txd      <= 1'b0;
      end else if (tx_st_q != S_IDLE && baud_tick) begin
         tx_cnt_q <= tx_bit_end ? '0 : tx_cnt_q + CW'(1);
         if (tx_bit_end) begin
            case (tx_st_q)
               S_START: begin
                  tx_st_q <= S_DATA;
                  txd     <= tx_sh_q[0];
               end
               S_DATA: begin
                  tx_bit_q <= tx_bit_q + 3'h1;
                  tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                  if (tx_bit_q != 3'h7) begin
                     txd <= tx_sh_q[1];
                  end else if (ctrl_q.frame_mode_select) begin
                     tx_st_q <= S_NINTH;
                     txd     <= ctrl_q.tx_ninth_bit;
                  end else begin
                     tx_st_q <= S_STOP;
                     txd     <= 1'b1;
                  end
               end
               S_NINTH: begin
                  tx_st_q <= S_STOP;
                  txd     <= 1'b1;
               end
               default: begin
                  tx_st_q <= S_IDLE;
                  txd     <= 1'b1;
               end
            endcase
         end
      end
   end

   // =====================================================================
   // receiver
   logic rx_bit_end;
   logic rx_stop_smp;
   logic rx_ninth_val;
   logic rx_addr_ok;
   logic rx_accept;

   assign rx_bit_end   = baud_tick && rx_cnt_q == CNT_LAST;
   assign rx_stop_smp  = rx_bit_end && rx_st_q == S_STOP;
   assign rx_ninth_val = ctrl_q.frame_mode_select ? rx_ninth_q : rxd;
   assign rx_addr_ok   = !ctrl_q.multiproc_enable || rx_ninth_val;
   assign rx_accept    = rx_stop_smp && rx_addr_ok
                         && !ctrl_q.rx_done_flag;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_st_q    <= S_IDLE;
         rx_cnt_q   <= '0;
         rx_bit_q   <= 3'h0;
         rx_sh_q    <= 8'h00;
         rx_ninth_q <= 1'b0;
         rxd_prev_q <= 1'b1;
      end else begin
         rxd_prev_q <= rxd;
         case (rx_st_q)
            S_IDLE: begin
               if (ctrl_q.receive_enable_bit && rxd_prev_q && !rxd) begin
                  rx_st_q  <= S_START;
                  rx_cnt_q <= '0;
               end
            end
            S_START: begin
               if (baud_tick && rx_cnt_q == CNT_HALF) begin
                  rx_st_q  <= rxd ? S_IDLE : S_DATA;
                  rx_cnt_q <= '0;
                  rx_bit_q <= 3'h0;
               end else if (baud_tick) begin
                  rx_cnt_q <= rx_cnt_q + CW'(1);
               end
            end
            S_DATA, S_NINTH, S_STOP: begin
               if (rx_bit_end) begin
                  rx_cnt_q <= '0;
                  if (rx_st_q == S_DATA) begin
                     rx_sh_q  <= {rxd, rx_sh_q[7:1]};
                     rx_bit_q <= rx_bit_q + 3'h1;
                     if (rx_bit_q == 3'h7) begin
                        rx_st_q <= ctrl_q.frame_mode_select ? S_NINTH
                                                            : S_STOP;
                     end
                  end else if (rx_st_q == S_NINTH) begin
                     rx_ninth_q <= rxd;
                     rx_st_q    <= S_STOP;
                  end else begin
                     rx_st_q <= S_IDLE;
                  end
               end else if (baud_tick) begin
                  rx_cnt_q <= rx_cnt_q + CW'(1);
               end
            end
            default: rx_st_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_latch_q <= DATA_RST;
      end else if (rx_accept) begin
         rx_latch_q <= rx_sh_q;
      end
   end

   // =====================================================================
   // control, status, mask and clock select registers
   logic clr_ti;
   logic clr_ri;

   assign clr_ti = wr_stat && w_data_q[STAT_TX];
   assign clr_ri = wr_stat && w_data_q[STAT_RX];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RST;
      end else begin
         ctrl_q.unused_one <= 1'b1;
         if (wr_ctrl) begin
            ctrl_q.frame_mode_select  <= w_ctrl.frame_mode_select;
            ctrl_q.multiproc_enable   <= w_ctrl.multiproc_enable;
            ctrl_q.receive_enable_bit <= w_ctrl.receive_enable_bit;
            ctrl_q.tx_ninth_bit       <= w_ctrl.tx_ninth_bit;
         end
         if (rx_accept) begin
            ctrl_q.rx_ninth_bit <= rx_ninth_val;
         end else if (wr_ctrl) begin
            ctrl_q.rx_ninth_bit <= w_ctrl.rx_ninth_bit;
         end
         // set beats a same-cycle clear
         ctrl_q.tx_done_flag <= tx_ti_set || (wr_ctrl ? w_ctrl.tx_done_flag
                                : ctrl_q.tx_done_flag && !clr_ti);
         ctrl_q.rx_done_flag <= rx_accept || (wr_ctrl ? w_ctrl.rx_done_flag
                                : ctrl_q.rx_done_flag && !clr_ri);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ovr_q <= 1'b0;
      end else begin
         ovr_q <= (rx_stop_smp && rx_addr_ok && ctrl_q.rx_done_flag)
                  || (ovr_q && !(wr_stat && w_data_q[STAT_OVR]));
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         clksel_q <= CLKSEL_RST;
         mask_q   <= MASK_RST;
      end else begin
         if (wr_clksel) begin
            clksel_q <= {5'h00, w_data_q[2:0]};
         end
         if (wr_mask) begin
            mask_q <= {5'h00, w_data_q[2:0]};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |({ovr_q, ctrl_q.rx_done_flag, ctrl_q.tx_done_flag}
                  & mask_q[2:0]);
      end
   end

   uctl_prescale u_prescale (
      .clk_sys      (clk_sys),
      .rst_n        (rst_n),
      .clksel       (clksel_q),
      .timer_clk_en (timer_clk_en)
   );

   // =====================================================================
   // checks
   sequence s_data_wr;
      wr_data;
   endsequence

   sequence s_start_bit;
      tx_st_q == S_START && !txd;
   endsequence

   a_ren_gates_rx: assert property (
      (rx_st_q == S_IDLE && !ctrl_q.receive_enable_bit) |=> rx_st_q == S_IDLE)
      else $error("receiver left idle while disabled");

   a_tx_ninth_level: assert property (
      (tx_st_q == S_NINTH && $past(tx_st_q) == S_DATA && !$past(wr_data))
      |-> txd == $past(ctrl_q.tx_ninth_bit))
      else $error("ninth bit not sent from control bit");

   a_mode8_no_ninth: assert property (
      (tx_st_q == S_DATA && !ctrl_q.frame_mode_select && !wr_data)
      |=> tx_st_q != S_NINTH)
      else $error("ninth bit sent in eight-bit mode");

   a_rb8_capture: assert property (
      rx_accept |=> ctrl_q.rx_ninth_bit == $past(rx_ninth_val))
      else $error("received ninth bit not stored");

   a_ti_at_stop: assert property (
      (tx_ti_set && !wr_data) |=> ctrl_q.tx_done_flag && tx_st_q == S_STOP
      && txd)
      else $error("tx done not set at stop bit");

   a_irq_tx: assert property (
      (ctrl_q.tx_done_flag && mask_q[STAT_TX]) |=> irq)
      else $error("tx done did not raise interrupt");

   a_irq_rx: assert property (
      (ctrl_q.rx_done_flag && mask_q[STAT_RX]) |=> irq)
      else $error("rx done did not raise interrupt");

   a_flag_sticky: assert property (
      (ctrl_q.rx_done_flag && !wr_ctrl && !clr_ri) |=> ctrl_q.rx_done_flag)
      else $error("rx done cleared by hardware");

   a_ri_at_stop: assert property (
      rx_accept |=> ctrl_q.rx_done_flag && rx_st_q == S_IDLE)
      else $error("rx done not set at stop sample");

   a_mce_filter: assert property (
      (rx_stop_smp && ctrl_q.multiproc_enable && !rx_ninth_val && !wr_ctrl
       && !clr_ri) |=> $stable(ctrl_q.rx_done_flag) && $stable(rx_latch_q))
      else $error("address filter let a frame through");

   a_latch_hold: assert property (
      (rx_stop_smp && ctrl_q.rx_done_flag) |=> $stable(rx_latch_q))
      else $error("receive latch overwritten while full");

   a_write_starts: assert property (
      s_data_wr |=> s_start_bit ##0 tx_sh_q == $past(w_data_q)
      ##0 $stable(rx_latch_q))
      else $error("data write did not start a frame");

   a_read_latch: assert property (
      (s_axi_arvalid && s_axi_arready && rd_sel == SEL_DATA)
      |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(rx_latch_q)})
      else $error("data read did not return receive latch");

   a_tick_paced: assert property (
      (tx_st_q != $past(tx_st_q) && !$past(wr_data) && $past(tx_st_q) != S_IDLE)
      |-> $past(baud_tick))
      else $error("transmit bit advanced without a tick");

   a_stop_high: assert property (
      tx_st_q == S_STOP |-> txd)
      else $error("stop bit not high");

endmodule

/* File: uctl_remote.sv */
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module uctl_remote (
   input  wire logic       clk_sys,
   input  wire logic       baud_tick,
   input  wire logic       go,
   input  wire logic       nine,
   input  wire logic [8:0] frm,
   output logic            rxd
);
   logic [10:0] sh = '1;
   logic [3:0]  n = 4'h0;
   logic [1:0]  t = 2'h0;
   // start, data lsb first, optional ninth, stop; four ticks a bit
   always_ff @(posedge clk_sys) begin
      if (go) begin
         sh <= nine ? {1'b1, frm, 1'b0} : {2'h3, frm[7:0], 1'b0};
         n  <= nine ? 4'hB : 4'hA;
         t  <= 2'h0;
      end else if (baud_tick && n != 4'h0) begin
         t <= t + 2'h1;
         if (t == 2'h3) begin
            sh <= {1'b1, sh[10:1]};
            n  <= n - 4'h1;
         end
      end
   end
   assign rxd = (n == 4'h0) ? 1'b1 : sh[0];
endmodule

/* File: uart0_control_and_data_buffer_bench.sv */
// testbench for the serial port control and data buffer
`timescale 1ns/1ps
module uart0_control_and_data_buffer_bench;
   import uctl_pkg::*;
   logic clk_sys, rst_n, baud_tick, rxd, txd, timer_clk_en, irq, go, nine;
   logic [9:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [8:0] frm;
   logic [10:0] f;
   int n_mismatch, tests_run, cyc, n;
   // address, write data, read back, response
   logic [27:0] rows [4] = '{{10'h260, 8'h38, 8'h78, 2'h0},
      {10'h26C, 8'h07, 8'h07, 2'h0}, {10'h268, 8'h05, 8'h05, 2'h0},
      {10'h000, 8'hFF, 8'h00, 2'h2}};
   logic [2:0] ps [4] = '{3'h4, 3'h1, 3'h0, 3'h2};
   int cnt [4] = '{96, 24, 8, 2};
   uctl_top #(.OVS(4)) uut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .baud_tick, .rxd, .txd,
      .timer_clk_en, .irq);
   uctl_remote peer (.clk_sys, .baud_tick, .go, .nine, .frm, .rxd);
   initial begin
      clk_sys = 0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      baud_tick <= ~baud_tick;
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_mismatch++;
         test_done;
      end
   end
   task test_done;
      if (n_mismatch == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wr(input logic [9:0] a, input logic [7:0] d);
      logic ta, tw;
      ta = 0;
      tw = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) begin
            ta = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            tw = 1;
            s_axi_wvalid <= 0;
         end
      end while (!(ta && tw));
      s_axi_bready <= 1;
      do @(posedge clk_sys); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task rd(input logic [9:0] a);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      s_axi_rready <= 1;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   task sd(input logic m, input logic [8:0] d);
      @(posedge clk_sys);
      go <= 1;
      nine <= m;
      frm <= d;
      @(posedge clk_sys);
      go <= 0;
      repeat (110) @(posedge clk_sys);
   endtask
   initial begin
      {rst_n, baud_tick, go, nine, frm, cyc, n_mismatch, tests_run} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = 0;
      {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1;
      foreach (rows[i]) begin
         wr(rows[i][27:18], rows[i][17:10]);
         chk("bresp", r, rows[i][1:0]);
         rd(rows[i][27:18]);
         chk("rdata", v, rows[i][9:2]);
         chk("rresp", r, rows[i][1:0]);
      end
      foreach (ps[i]) begin
         wr(10'h268, ps[i]);
         repeat (8) @(posedge clk_sys);
         n = 0;
         repeat (96) @(posedge clk_sys) n += timer_clk_en;
         chk("timer_clk_en", n, cnt[i]);
      end
      wr(10'h26C, 8'h01);
      for (int m = 0; m < 2; m++) begin
         wr(10'h260, m ? 8'h80 : 8'h08);
         wr(10'h270, 8'h07);
         wr(10'h264, 8'hA5);
         f = {1'b1, m == 0, 8'hA5, 1'b0};
         while (txd) @(posedge clk_sys);
         repeat (4) @(posedge clk_sys);
         for (int i = 0; i < 11; i++) begin
            chk("txd", txd, f[i]);
            repeat (8) @(posedge clk_sys);
         end
         chk("irq", irq, 1);
         rd(10'h260);
         chk("ctrl", v, m ? 8'hC2 : 8'h4A);
      end
      rd(10'h264);
      chk("data", v, 8'h00);
      wr(10'h270, 8'h07);
      wr(10'h260, 8'h00);
      wr(10'h26C, 8'h02);
      sd(0, 9'h03C);
      rd(10'h260);
      chk("ctrl", v, 8'h40);
      wr(10'h260, 8'h10);
      sd(0, 9'h05A);
      rd(10'h264);
      chk("data", v, 8'h5A);
      rd(10'h260);
      chk("ctrl", v, 8'h55);
      chk("irq", irq, 1);
      sd(0, 9'h011);
      rd(10'h264);
      chk("data", v, 8'h5A);
      rd(10'h270);
      chk("stat", v, 8'h06);
      wr(10'h260, 8'hB0);
      sd(1, 9'h022);
      rd(10'h260);
      chk("ctrl", v, 8'hF0);
      sd(1, 9'h133);
      rd(10'h264);
      chk("data", v, 8'h33);
      rd(10'h260);
      chk("ctrl", v, 8'hF5);
      rst_n <= 0;
      repeat (5) @(posedge clk_sys);
      chk("irq", irq, 0);
      rst_n <= 1;
      rd(10'h260);
      chk("ctrl", v, 8'h40);
      rd(10'h268);
      chk("clksel", v, 8'h00);
      test_done;
   end
endmodule
